// [hsz_homing_seq.sv]
// Purpose: homing sequencer, sensor front edge with or without index
// Assumes: sensors and index come from pins; position loop shares i_mclk
// Notes:   registers over AHB-Lite, zero wait state, response always OKAY
//
// How it works
// R01: type 0 runs fast to sensor edge, backs out, re-finds edge slowly.
// R02: then counts index pulses to the set count; that spot is home.
// R03: type 1 takes the slow re-detection point as home, no counting.
// R04: home is where the count completes, even outside the sensor area.
// R05: homing type field: 0 sensor plus index, 1 sensor only.
// R06: direction field: 0 positive travel, 1 negative travel.
// R07: fast speed setting 0 to 6000 r/min for the first approach.
// R08: slow speed setting 0 to 6000 r/min for the re-detection.
// R09: offset speed setting 0 to 6000 r/min for the offset move.
// R10: accel and decel settings up to 3000 govern the ramps.
// R11: offset enable: 0 no offset move, 1 offset move after home.
// R12: index count setting picks which index pulse ends homing.
// R13: signed home offset in pulses; zero means no offset.
// R14: start with zero fast, slow, accel or decel trips error 68.
// R15: reversed at limit, no sensor off seen, opposite limit trips 68.
// R16: limit in travel direction while counting index trips 68.
// R17: limit stop decelerates for action 0 or 2, instant for 1 or 3.
// R18: home presets positions; done output pulses, then follows deviation.
// R19: installer keeps sensor signals steady while decelerating.
// R20: installer keeps index pulses away from the count start point.
// R21: complete flag set only on normal finish; start clears it.
// R22: stop, servo off or trip aborts and leaves homing incomplete.
// R23: offset enabled: move by offset at offset speed before completion.
`timescale 1ns/1ps
module hsz_homing_seq (
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_home_sensor,
    input  wire logic        i_limit_pos,
    input  wire logic        i_limit_neg,
    input  wire logic        i_index,
    input  wire logic        i_stop_req,
    input  wire logic        i_servo_on,
    input  wire logic        i_trip,
    input  wire logic        i_motor_stopped,
    input  wire logic        i_in_position,
    input  wire logic [31:0] i_position,
    output logic      [13:0] o_speed_cmd,
    output logic      [11:0] o_accel,
    output logic      [11:0] o_decel,
    output logic             o_quick_stop,
    output logic             o_preset,
    output logic      [31:0] o_preset_pos,
    output logic             o_pos_done,
    output logic             o_busy,
    output logic             o_home_done,
    output logic             o_home_error
);
    localparam int SW = hsz_pkg::SPD_W;
    localparam int AW = hsz_pkg::ACC_W;
    localparam int CW = hsz_pkg::CNT_W;

    typedef enum logic [3:0] {
        ST_IDLE, ST_FAST, ST_TURN, ST_BRAKE1, ST_BACK, ST_BRAKE2,
        ST_SLOW, ST_INDEX, ST_OFFSET, ST_SETTLE
    } hsz_state_type;

    // pin synchronisers: stage 1 feeds only stage 2
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic [3:0] pin_d_reg;
    wire  [3:0] pin_raw = {i_index, i_limit_neg, i_limit_pos, i_home_sensor};

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            pin_d_reg  <= 4'h0;
        end else if (i_ce) begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg  <= pin_s2_reg;
        end
    end

    wire home      = pin_s2_reg[0];
    wire home_rise = pin_s2_reg[0] & ~pin_d_reg[0];
    wire home_fall = ~pin_s2_reg[0] & pin_d_reg[0];
    wire index_rise = pin_s2_reg[3] & ~pin_d_reg[3];

    // configuration registers
    logic          type_reg;
    logic          dir_reg;
    logic          ofs_en_reg;
    logic [1:0]    ot_act_reg;
    logic [SW-1:0] fast_reg;
    logic [SW-1:0] slow_reg;
    logic [SW-1:0] ofs_spd_reg;
    logic [AW-1:0] accel_reg;
    logic [AW-1:0] decel_reg;
    logic [CW-1:0] icnt_set_reg;
    logic [31:0]   offset_reg;

    // bus address phase capture
    logic          wr_pend_reg;
    logic [7:0]    wr_addr_reg;
    logic [31:0]   rdata_reg;
    logic [31:0]   rd_mux;
    wire           addr_ok = i_hsel & i_htrans[1] & i_hready;
    wire           wr_take = addr_ok & i_hwrite;
    wire           rd_take = addr_ok & ~i_hwrite;
    wire           wr_ctrl = wr_pend_reg & (wr_addr_reg == hsz_pkg::ADDR_CTRL);
    wire           start_w = wr_ctrl & i_hwdata[hsz_pkg::CTRL_START];
    wire           abort_w = wr_ctrl & i_hwdata[hsz_pkg::CTRL_ABORT];

    // write data clipped to the documented ranges
    wire [SW-1:0]  wd_spd  = (i_hwdata[SW-1:0] > hsz_pkg::SPD_MAX) ?
                             hsz_pkg::SPD_MAX : i_hwdata[SW-1:0];
    wire [AW-1:0]  wd_acc  = (i_hwdata[AW-1:0] > hsz_pkg::ACC_MAX) ?
                             hsz_pkg::ACC_MAX : i_hwdata[AW-1:0];

    // sequencer state
    hsz_state_type state_reg;
    hsz_state_type state_next;
    logic          rev_reg;
    logic          rev_next;
    logic          seen_home_reg;
    logic          seen_home_next;
    logic [CW-1:0] icnt_reg;
    logic [CW-1:0] icnt_next;
    logic          done_reg;
    logic          err_reg;
    logic          quick_next;
    logic          preset_next;
    logic          finish_next;
    logic          fail_next;

    wire busy      = (state_reg != ST_IDLE);
    wire bad_cfg   = (fast_reg == '0) | (slow_reg == '0) |
                     (accel_reg == '0) | (decel_reg == '0);
    wire interrupt = i_stop_req | ~i_servo_on | i_trip | abort_w;
    wire lim_fwd   = dir_reg ? pin_s2_reg[2] : pin_s2_reg[1];
    wire lim_bwd   = dir_reg ? pin_s2_reg[1] : pin_s2_reg[2];
    wire ot_quick  = ot_act_reg[0];
    wire [CW-1:0] icnt_inc  = icnt_reg + CW'(1);
    wire          icnt_hit  = (icnt_inc >= icnt_set_reg);
    wire          ofs_zero  = (offset_reg == 32'h0000_0000);
    wire          ofs_neg   = offset_reg[31];
    wire          ofs_reach = ofs_neg ? ($signed(i_position) <= $signed(offset_reg)) :
                                        ($signed(i_position) >= $signed(offset_reg));

    always_comb begin
        state_next     = state_reg;
        rev_next       = rev_reg;
        seen_home_next = seen_home_reg;
        icnt_next      = icnt_reg;
        quick_next     = 1'b0;
        preset_next    = 1'b0;
        finish_next    = 1'b0;
        fail_next      = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                rev_next       = 1'b0;
                seen_home_next = 1'b0;
                icnt_next      = '0;
                if (start_w && !interrupt) begin
                    if (bad_cfg) begin
                        fail_next = 1'b1; // R14
                    end else if (home) begin
                        state_next = ST_BRAKE1; // R01
                    end else begin
                        state_next = ST_FAST; // R01
                    end
                end
            end
            ST_FAST: begin
                if (!rev_reg) begin
                    if (home_rise) begin
                        state_next = ST_BRAKE1; // R01
                    end else if (lim_fwd) begin
                        quick_next = ot_quick; // R17
                        rev_next   = 1'b1;
                        state_next = ST_TURN;
                    end
                end else begin
                    if (home) begin
                        seen_home_next = 1'b1;
                    end
                    if (lim_bwd) begin
                        quick_next = ot_quick; // R17
                        fail_next  = 1'b1; // R15
                    end else if (home_fall && seen_home_reg) begin
                        rev_next   = 1'b0;
                        state_next = ST_TURN;
                    end
                end
            end
            ST_TURN: begin
                quick_next = ot_quick; // R17
                if (i_motor_stopped) begin
                    seen_home_next = 1'b0;
                    state_next     = ST_FAST;
                end
            end
            ST_BRAKE1: begin
                if (i_motor_stopped) begin
                    state_next = ST_BACK;
                end
            end
            ST_BACK: begin
                if (lim_bwd) begin
                    quick_next = ot_quick; // R17
                    fail_next  = 1'b1;
                end else if (!home) begin
                    state_next = ST_BRAKE2; // R01
                end
            end
            ST_BRAKE2: begin
                if (i_motor_stopped) begin
                    state_next = ST_SLOW;
                end
            end
            ST_SLOW: begin
                if (lim_fwd) begin
                    quick_next = ot_quick; // R17
                    fail_next  = 1'b1;
                end else if (home_rise) begin
                    if (type_reg) begin
                        preset_next = 1'b1; // R03
                        state_next  = ofs_en_reg ? ST_OFFSET : ST_SETTLE;
                    end else begin
                        icnt_next  = '0;
                        state_next = ST_INDEX; // R02
                    end
                end
            end
            ST_INDEX: begin
                // sensor level is ignored here on purpose
                if (lim_fwd) begin
                    quick_next = ot_quick; // R17
                    fail_next  = 1'b1; // R16
                end else if (index_rise) begin
                    icnt_next = icnt_inc; // R12
                    if (icnt_hit) begin
                        preset_next = 1'b1; // R04
                        state_next  = ofs_en_reg ? ST_OFFSET : ST_SETTLE; // R02
                    end
                end
            end
            ST_OFFSET: begin
                if (ofs_zero || ofs_reach) begin
                    state_next = ST_SETTLE; // R23
                end
            end
            ST_SETTLE: begin
                if (i_motor_stopped) begin
                    finish_next = 1'b1; // R21
                    state_next  = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (fail_next || (busy && interrupt)) begin
            state_next  = ST_IDLE; // R22
            finish_next = 1'b0;
            preset_next = 1'b0;
        end
    end

    // speed command per state, sign from direction and phase, from the offset sign in ST_OFFSET
    logic [SW-1:0] spd_mag;
    logic          spd_neg;
    always_comb begin
        spd_mag = '0;
        spd_neg = dir_reg; // R06
        case (state_reg)
            ST_FAST: begin
                spd_mag = fast_reg; // R07
                spd_neg = dir_reg ^ rev_reg;
            end
            ST_BACK: begin
                spd_mag = slow_reg;
                spd_neg = ~dir_reg;
            end
            ST_SLOW, ST_INDEX: begin
                spd_mag = slow_reg; // R08
            end
            ST_OFFSET: begin
                spd_mag = ofs_spd_reg; // R09
                spd_neg = ofs_neg; // R13
            end
            default: begin
                spd_mag = '0;
            end
        endcase
    end
    wire [13:0] spd_ext = {1'b0, spd_mag};
    wire [13:0] spd_cmd = spd_neg ? 14'(-spd_ext) : spd_ext;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state_reg     <= ST_IDLE;
            rev_reg       <= 1'b0;
            seen_home_reg <= 1'b0;
            icnt_reg      <= '0;
            done_reg      <= 1'b0;
            err_reg       <= 1'b0;
            o_speed_cmd   <= 14'h0000;
            o_quick_stop  <= 1'b0;
            o_preset      <= 1'b0;
            o_pos_done    <= 1'b0;
        end else if (i_ce) begin
            state_reg     <= state_next;
            rev_reg       <= rev_next;
            seen_home_reg <= seen_home_next;
            icnt_reg      <= icnt_next;
            o_speed_cmd   <= (state_next == state_reg) ? spd_cmd : 14'h0000;
            o_quick_stop  <= quick_next;
            o_preset      <= preset_next; // R18
            o_pos_done    <= preset_next | i_in_position; // R18
            if (start_w && !busy) begin
                done_reg <= 1'b0; // R21
                err_reg  <= fail_next; // R14
            end else if (fail_next) begin
                err_reg  <= 1'b1;
            end
            if (finish_next) begin
                done_reg <= 1'b1; // R21
            end else if (busy && interrupt) begin
                done_reg <= 1'b0; // R22
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            wr_pend_reg  <= 1'b0;
            wr_addr_reg  <= 8'h00;
            rdata_reg    <= 32'h0000_0000;
            type_reg     <= 1'b0;
            dir_reg      <= 1'b0;
            ofs_en_reg   <= 1'b0;
            ot_act_reg   <= 2'h0;
            fast_reg     <= hsz_pkg::RST_SPD;
            slow_reg     <= hsz_pkg::RST_SPD;
            ofs_spd_reg  <= hsz_pkg::RST_SPD;
            accel_reg    <= hsz_pkg::RST_ACC;
            decel_reg    <= hsz_pkg::RST_ACC;
            icnt_set_reg <= hsz_pkg::RST_CNT;
            offset_reg   <= 32'h0000_0000;
        end else if (i_ce) begin
            wr_pend_reg <= wr_take;
            wr_addr_reg <= i_haddr[7:0];
            if (rd_take) begin
                rdata_reg <= rd_mux;
            end
            // settings are frozen while a sequence runs
            if (wr_pend_reg && !busy) begin
                case (wr_addr_reg)
                    hsz_pkg::ADDR_CTRL: begin
                        type_reg   <= i_hwdata[hsz_pkg::CTRL_TYPE]; // R05
                        dir_reg    <= i_hwdata[hsz_pkg::CTRL_DIR]; // R06
                        ofs_en_reg <= i_hwdata[hsz_pkg::CTRL_OFS_EN]; // R11
                        ot_act_reg <= i_hwdata[hsz_pkg::CTRL_OT_LSB +: 2]; // R17
                    end
                    hsz_pkg::ADDR_FAST_SPD:  fast_reg     <= wd_spd; // R07
                    hsz_pkg::ADDR_SLOW_SPD:  slow_reg     <= wd_spd; // R08
                    hsz_pkg::ADDR_OFS_SPD:   ofs_spd_reg  <= wd_spd; // R09
                    hsz_pkg::ADDR_ACCEL:     accel_reg    <= wd_acc; // R10
                    hsz_pkg::ADDR_DECEL:     decel_reg    <= wd_acc; // R10
                    hsz_pkg::ADDR_INDEX_CNT: icnt_set_reg <= i_hwdata[CW-1:0]; // R12
                    hsz_pkg::ADDR_OFFSET:    offset_reg   <= i_hwdata; // R13
                    default: begin
                    end
                endcase
            end
        end
    end

    // read mux, sampled in the address phase
    wire  [31:0] ctrl_rd = {25'h0, ot_act_reg, ofs_en_reg, dir_reg, type_reg, 2'b00};
    wire  [31:0] stat_rd = {16'h0, err_reg ? hsz_pkg::ERR_HOMING : 8'h00,
                            state_reg, 1'b0, err_reg, done_reg, busy};
    always_comb begin
        case (i_haddr[7:0])
            hsz_pkg::ADDR_CTRL:      rd_mux = ctrl_rd;
            hsz_pkg::ADDR_FAST_SPD:  rd_mux = {19'h0, fast_reg};
            hsz_pkg::ADDR_SLOW_SPD:  rd_mux = {19'h0, slow_reg};
            hsz_pkg::ADDR_OFS_SPD:   rd_mux = {19'h0, ofs_spd_reg};
            hsz_pkg::ADDR_ACCEL:     rd_mux = {20'h0, accel_reg};
            hsz_pkg::ADDR_DECEL:     rd_mux = {20'h0, decel_reg};
            hsz_pkg::ADDR_INDEX_CNT: rd_mux = {24'h0, icnt_set_reg};
            hsz_pkg::ADDR_OFFSET:    rd_mux = offset_reg;
            hsz_pkg::ADDR_STATUS:    rd_mux = stat_rd;
            hsz_pkg::ADDR_POSITION:  rd_mux = i_position;
            default:                 rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_hreadyout  <= 1'b0;
            o_hresp      <= 1'b0;
            o_accel      <= 12'h000;
            o_decel      <= 12'h000;
            o_preset_pos <= 32'h0000_0000;
            o_busy       <= 1'b0;
            o_home_done  <= 1'b0;
            o_home_error <= 1'b0;
        end else if (i_ce) begin
            o_hreadyout  <= 1'b1;
            o_hresp      <= 1'b0;
            o_accel      <= accel_reg; // R10
            o_decel      <= decel_reg; // R10
            o_preset_pos <= hsz_pkg::HOME_POS; // R18
            o_busy       <= (state_next != ST_IDLE);
            o_home_done  <= (done_reg & ~start_w) | finish_next;
            o_home_error <= (err_reg & ~start_w) | fail_next;
        end
    end

    assign o_hrdata = rdata_reg;
endmodule

// [hsz_pkg.sv]
// Purpose: homing sequencer constants
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes:   speeds in r/min, positions in encoder pulses
package hsz_pkg;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_FAST_SPD  = 8'h04;
    localparam logic [7:0]  ADDR_SLOW_SPD  = 8'h08;
    localparam logic [7:0]  ADDR_OFS_SPD   = 8'h0C;
    localparam logic [7:0]  ADDR_ACCEL     = 8'h10;
    localparam logic [7:0]  ADDR_DECEL     = 8'h14;
    localparam logic [7:0]  ADDR_INDEX_CNT = 8'h18;
    localparam logic [7:0]  ADDR_OFFSET    = 8'h1C;
    localparam logic [7:0]  ADDR_STATUS    = 8'h20;
    localparam logic [7:0]  ADDR_POSITION  = 8'h24;

    localparam int          CTRL_START     = 0;
    localparam int          CTRL_ABORT     = 1;
    localparam int          CTRL_TYPE      = 2;
    localparam int          CTRL_DIR       = 3;
    localparam int          CTRL_OFS_EN    = 4;
    localparam int          CTRL_OT_LSB    = 5;

    localparam int          STAT_BUSY      = 0;
    localparam int          STAT_DONE      = 1;
    localparam int          STAT_ERROR     = 2;
    localparam int          STAT_CODE_LSB  = 8;

    localparam int          SPD_W          = 13;
    localparam int          ACC_W          = 12;
    localparam int          CNT_W          = 8;

    localparam logic [SPD_W-1:0] SPD_MAX   = 13'h1770;
    localparam logic [ACC_W-1:0] ACC_MAX   = 12'h0BB8;
    localparam logic [7:0]  ERR_HOMING     = 8'h44;
    localparam logic [31:0] HOME_POS       = 32'h0000_0000;

    localparam logic [1:0]  TYPE_SENSOR_Z  = 2'h0;
    localparam logic [1:0]  TYPE_SENSOR    = 2'h1;

    localparam logic [SPD_W-1:0] RST_SPD   = 13'h0000;
    localparam logic [ACC_W-1:0] RST_ACC   = 12'h000;
    localparam logic [CNT_W-1:0] RST_CNT   = 8'h01;
endpackage

// [hsz_properties.sv]
// Purpose: port-level checks of the homing sequencer
// Assumes: single clock, synchronous active-low reset
// Notes:   attached by bind below
`timescale 1ns/1ps
module hsz_properties (
    input wire logic        i_mclk,
    input wire logic        i_rstn,
    input wire logic        i_trip,
    input wire logic        o_hresp,
    input wire logic [13:0] o_speed_cmd,
    input wire logic [11:0] o_accel,
    input wire logic [11:0] o_decel,
    input wire logic        o_preset,
    input wire logic [31:0] o_preset_pos,
    input wire logic        o_pos_done,
    input wire logic        o_busy,
    input wire logic        o_home_done,
    input wire logic        o_home_error
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    property p_okay; o_hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");
    property p_preset_once; o_preset |=> !o_preset; endproperty
    a_preset_once: assert property (p_preset_once) else $error("preset too long");
    property p_preset_zero; o_preset |-> o_preset_pos == hsz_pkg::HOME_POS; endproperty
    a_preset_zero: assert property (p_preset_zero) else $error("preset value wrong");
    property p_pos_done; $rose(o_preset) |-> ##[0:1] o_pos_done; endproperty
    a_pos_done: assert property (p_pos_done) else $error("done output missed");
    property p_preset_busy; o_preset |-> o_busy && !o_home_done; endproperty
    a_preset_busy: assert property (p_preset_busy) else $error("preset outside run");
    property p_done_idle; o_home_done |-> !o_busy && !o_home_error; endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while running");
    property p_err_idle; o_home_error |-> !o_busy; endproperty
    a_err_idle: assert property (p_err_idle) else $error("error while running");
    property p_trip; i_trip && o_busy |-> ##[1:4] (!o_busy && !o_home_done); endproperty
    a_trip: assert property (p_trip) else $error("trip did not abort");
    property p_spd;
        $signed(o_speed_cmd) <= 6000 && $signed(o_speed_cmd) >= -6000;
    endproperty
    a_spd: assert property (p_spd) else $error("speed out of range");
    property p_ramp;
        o_accel <= hsz_pkg::ACC_MAX && o_decel <= hsz_pkg::ACC_MAX;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp out of range");
    property p_still; !o_busy && !$past(o_busy) |-> o_speed_cmd == 14'h0000; endproperty
    a_still: assert property (p_still) else $error("motion while idle");
endmodule
bind hsz_homing_seq hsz_properties i_hsz_properties (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_trip(i_trip), .o_hresp(o_hresp), .o_speed_cmd(o_speed_cmd), .o_accel(o_accel),
    .o_decel(o_decel), .o_preset(o_preset), .o_preset_pos(o_preset_pos),
    .o_pos_done(o_pos_done), .o_busy(o_busy), .o_home_done(o_home_done),
    .o_home_error(o_home_error));

// [hsz_axis_model.sv]
// Purpose: axis with home sensor, limits and index pulse
// Assumes: one pulse per cycle of travel while speed is nonzero
// Notes:   sensor area 100..140, index every 32 pulses
`timescale 1ns/1ps
module hsz_axis_model (
    input  wire logic        i_mclk,
    input  wire logic [13:0] i_speed_cmd,
    input  wire logic        i_preset,
    output logic             o_home_sensor,
    output logic             o_limit_pos,
    output logic             o_limit_neg,
    output logic             o_index,
    output logic             o_motor_stopped,
    output logic             o_in_position,
    output logic      [31:0] o_position,
    output int               o_index_count
);
    int   abs_pos = 0;
    int   base    = 0;
    logic home_d  = 0;
    logic idx_d   = 0;
    // levels follow position, steady while braking
    assign o_home_sensor   = abs_pos >= 100 && abs_pos <= 140;
    assign o_limit_pos     = abs_pos >= 1000;
    assign o_limit_neg     = abs_pos <= -1000;
    // first index at 128, clear of the count start at 100
    assign o_index         = abs_pos % 32 == 0;
    assign o_motor_stopped = i_speed_cmd == 14'h0000;
    assign o_in_position   = o_motor_stopped;
    assign o_position      = 32'(abs_pos - base);
    always @(posedge i_mclk) begin
        if (i_speed_cmd != 14'h0000) abs_pos <= abs_pos + (i_speed_cmd[13] ? -1 : 1);
        if (i_preset) base <= abs_pos;
        home_d <= o_home_sensor;
        idx_d  <= o_index;
        if (o_home_sensor && !home_d) o_index_count <= 0;
        else if (o_index && !idx_d) o_index_count <= o_index_count + 1;
    end
endmodule

// [tb_top.sv]
// Purpose: self-checking bench of the homing sequencer
// Assumes: AHB-Lite master tasks, axis model
// Notes:   every wait is bounded
`timescale 1ns/1ps
module tb_top;
    logic             clk, rstn, hsel, hwrite, trip;
    logic      [31:0] haddr, hwdata, rd;
    logic      [1:0]  htrans;
    wire logic [31:0] hrdata, pos, ppos;
    wire logic [13:0] spd;
    wire logic [11:0] acc, dec;
    wire logic        hready, hresp, home, lim_p, lim_n, idx, still, inpos;
    wire logic        qstop, preset, pdone, busy, hdone, herr;
    int               mismatches, comparisons, icnt, icnt_pre;
    hsz_homing_seq i_hsz_homing_seq (.i_mclk(clk), .i_rstn(rstn), .i_ce(1'b1), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_home_sensor(home), .i_limit_pos(lim_p), .i_limit_neg(lim_n),
        .i_index(idx), .i_stop_req(1'b0), .i_servo_on(1'b1), .i_trip(trip),
        .i_motor_stopped(still), .i_in_position(inpos), .i_position(pos),
        .o_speed_cmd(spd), .o_accel(acc), .o_decel(dec), .o_quick_stop(qstop),
        .o_preset(preset), .o_preset_pos(ppos), .o_pos_done(pdone), .o_busy(busy),
        .o_home_done(hdone), .o_home_error(herr));
    hsz_axis_model i_hsz_axis_model (.i_mclk(clk), .i_speed_cmd(spd), .i_preset(preset),
        .o_home_sensor(home), .o_limit_pos(lim_p), .o_limit_neg(lim_n), .o_index(idx),
        .o_motor_stopped(still), .o_in_position(inpos), .o_position(pos),
        .o_index_count(icnt));
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (preset === 1'b1) icnt_pre <= icnt;
    task end_sim;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task wait_sig(input int sel, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((sel == 0 ? busy : sel == 1 ? herr : hready) !== v && n < lim);
        if (n >= lim) begin
            mismatches++;
            end_sim;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0000_00, a};
        wait_sig(2, 1'b1, 50);
        htrans <= 2'h0;
        hwdata <= d;
        wait_sig(2, 1'b1, 50);
        rd = hrdata;
    endtask
    task t_regs;
        bus(0, hsz_pkg::ADDR_INDEX_CNT, 0);
        chk("index_rst", rd, {24'h0000_00, hsz_pkg::RST_CNT});
        bus(1, hsz_pkg::ADDR_FAST_SPD, 32'h0000_1B58);
        bus(0, hsz_pkg::ADDR_FAST_SPD, 0);
        chk("fast_clip", rd, {19'h0_0000, hsz_pkg::SPD_MAX});
        bus(1, hsz_pkg::ADDR_ACCEL, 32'h0000_0FA0);
        bus(1, hsz_pkg::ADDR_DECEL, 32'h0000_0064);
        bus(0, hsz_pkg::ADDR_ACCEL, 0);
        chk("accel_clip", rd, {20'h0_0000, hsz_pkg::ACC_MAX});
        bus(0, 8'h40, 0);
        chk("unmapped", rd, 32'h0000_0000);
    endtask
    task t_zero;
        bus(1, hsz_pkg::ADDR_CTRL, 32'h0000_0001);
        wait_sig(1, 1'b1, 20);
        bus(0, hsz_pkg::ADDR_STATUS, 0);
        chk("zero_slow", rd & 32'h0000_FF07, {16'h0000, hsz_pkg::ERR_HOMING, 8'h04});
    endtask
    task t_home_z;
        bus(1, hsz_pkg::ADDR_SLOW_SPD, 32'h0000_0010);
        bus(1, hsz_pkg::ADDR_INDEX_CNT, 32'h0000_0003);
        bus(1, hsz_pkg::ADDR_CTRL, 32'h0000_0001);
        wait_sig(0, 1'b1, 20);
        @(posedge clk);
        chk("fast_fwd", 32'(spd), 32'h0000_1770);
        wait_sig(0, 1'b0, 3000);
        chk("done_z", 32'(hdone), 32'h1);
        chk("index_cnt", icnt_pre, 32'h3);
    endtask
    task t_home_s;
        bus(1, hsz_pkg::ADDR_OFS_SPD, 32'h0000_0020);
        bus(1, hsz_pkg::ADDR_OFFSET, 32'h0000_0014);
        bus(1, hsz_pkg::ADDR_CTRL, 32'h0000_001D);
        wait_sig(0, 1'b1, 20);
        @(posedge clk);
        chk("fast_rev", 32'(spd), 32'h0000_2890);
        wait_sig(0, 1'b0, 3000);
        chk("done_s", 32'(hdone), 32'h1);
        chk("no_count", icnt_pre, 32'h0);
        chk("offset", 32'($signed(pos) >= 20), 32'h1);
    endtask
    task t_abort;
        bus(1, hsz_pkg::ADDR_CTRL, 32'h0000_0001);
        wait_sig(0, 1'b1, 20);
        chk("start_clr", 32'(hdone), 32'h0);
        trip <= 1'b1;
        repeat (5) @(posedge clk);
        chk("trip_busy", 32'(busy), 32'h0);
        chk("trip_done", 32'(hdone), 32'h0);
        trip <= 1'b0;
    endtask
    initial begin
        {rstn, hsel, hwrite, trip} = 4'h0;
        haddr  = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs;
        t_zero;
        t_home_z;
        t_home_s;
        t_abort;
        end_sim;
    end
endmodule
